// *** common/swm_pkg.sv ***
// ----------------------------------------------------------------
// Single-wire bus master constants
// ----------------------------------------------------------------
package swm_pkg;

  // Functional clock rate in cycles per microsecond
  localparam int CLK_MHZ = 25;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // Pulse-width mode times, microseconds
  // ----------------------------------------------------------------
  localparam int BREAK_TIME_US = 200;
  localparam int BREAK_RECOVERY_TIME_US = 50;
  localparam int WRITE_BIT_WINDOW_US = 200;
  localparam int WRITE_ONE_LOW_TIME_US = 10;
  localparam int WRITE_ZERO_LOW_TIME_US = 110;
  localparam int SAMPLE_FIRST_US = 68;
  localparam int SAMPLE_SECOND_US = 180;
  // Slave response 320 us plus read window 250 us, with margin
  localparam int RESPONSE_TIMEOUT_US = 600;
  localparam int RELEASE_TIMEOUT_US = 1000;

  // ----------------------------------------------------------------
  // Reset/presence mode times, microseconds
  // ----------------------------------------------------------------
  localparam int BUS_RESET_LOW_TIME_US = 600;
  localparam int BUS_RESET_HIGH_TIME_US = 500;
  // Presence starts by 60 us and lasts at least 60 us
  localparam int PRESENCE_SAMPLE_US = 70;
  localparam int SLOT_TIME_US = 80;
  localparam int SLOT_ONE_LOW_TIME_US = 6;
  localparam int SLOT_ZERO_LOW_TIME_US = 70;
  localparam int SLOT_RECOVERY_TIME_US = 2;
  localparam int READ_STROBE_TIME_US = 1;
  // Just inside the 15 us read valid time
  localparam int SLOT_SAMPLE_US = 13;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int BREAK_CYC = BREAK_TIME_US * CLK_MHZ;
  localparam int BREAK_RECOVERY_CYC = BREAK_RECOVERY_TIME_US * CLK_MHZ;
  localparam int WRITE_BIT_WINDOW_CYC = WRITE_BIT_WINDOW_US * CLK_MHZ;
  localparam int WRITE_ONE_LOW_CYC = WRITE_ONE_LOW_TIME_US * CLK_MHZ;
  localparam int WRITE_ZERO_LOW_CYC = WRITE_ZERO_LOW_TIME_US * CLK_MHZ;
  localparam int SAMPLE_FIRST_CYC = SAMPLE_FIRST_US * CLK_MHZ;
  localparam int SAMPLE_SECOND_CYC = SAMPLE_SECOND_US * CLK_MHZ;
  localparam int RESPONSE_TIMEOUT_CYC = RESPONSE_TIMEOUT_US * CLK_MHZ;
  localparam int RELEASE_TIMEOUT_CYC = RELEASE_TIMEOUT_US * CLK_MHZ;
  localparam int BUS_RESET_LOW_CYC = BUS_RESET_LOW_TIME_US * CLK_MHZ;
  localparam int BUS_RESET_HIGH_CYC = BUS_RESET_HIGH_TIME_US * CLK_MHZ;
  localparam int PRESENCE_SAMPLE_CYC = PRESENCE_SAMPLE_US * CLK_MHZ;
  localparam int SLOT_CYC = SLOT_TIME_US * CLK_MHZ;
  localparam int SLOT_ONE_LOW_CYC = SLOT_ONE_LOW_TIME_US * CLK_MHZ;
  localparam int SLOT_ZERO_LOW_CYC = SLOT_ZERO_LOW_TIME_US * CLK_MHZ;
  localparam int SLOT_RECOVERY_CYC = SLOT_RECOVERY_TIME_US * CLK_MHZ;
  localparam int READ_STROBE_CYC = READ_STROBE_TIME_US * CLK_MHZ;
  localparam int SLOT_SAMPLE_CYC = SLOT_SAMPLE_US * CLK_MHZ;

  // Reset values
  localparam logic LINE_IDLE = 1'h1;

  // Commands
  typedef enum logic [1:0] {
    SWM_CMD_INIT = 2'h0,
    SWM_CMD_WRITE = 2'h1,
    SWM_CMD_READ = 2'h2
  } swm_cmd_t;

endpackage

// *** rtl/swm_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Pin synchroniser with agreement filter
// ----------------------------------------------------------------
module swm_sync (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic pin_i,
  output logic level_q
);
  import swm_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } swm_sync_t;

  swm_sync_t q;
  swm_sync_t d;

  // Level moves only when the second and third stages agree
  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.lvl = q.s2;
    end
  end

  // Idle line reads high so reset cannot fake a falling edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= {LINE_IDLE, LINE_IDLE, LINE_IDLE, LINE_IDLE};
    end else begin
      q <= d;
    end
  end

  assign level_q = q.lvl;
endmodule
`default_nettype wire

// *** rtl/swm_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Elapsed-cycle counter
// ----------------------------------------------------------------
module swm_timer #(
  parameter int CNT_W = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clear,
  output logic [CNT_W-1:0] elapsed
);
  import swm_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } swm_timer_t;

  swm_timer_t q;
  swm_timer_t d;

  // Saturates so a stuck phase never wraps into a false match
  always_comb begin
    d = q;
    if (clear) begin
      d.cnt = '0;
    end else if (q.cnt != {CNT_W{1'b1}}) begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign elapsed = q.cnt;
endmodule
`default_nettype wire

// *** rtl/swm_master.sv ***
// Function
// - Pulse-width read low at both samples is reported as slave break.
// - Pulse-width read low then high records a zero bit.
// - Pulse-width read high at both samples records a one bit.
// - Pulse-width read samples at 68 us and 180 us after falling edge.
// - Pulse-width transaction opens with a break low at least 190 us.
// - After break, line released high at least 40 us before first bit.
// - Pulse-width written bit window is at least 190 us edge to edge.
// - Pulse-width one is low 0.5 to 50 us, then released.
// - Pulse-width zero is low 86 to 145 us, then released.
// - Slot mode opens with reset pulse low 480 to 960 us.
// - After reset, line released at least 480 us watching presence.
// - Slot mode bit slots last 60 to 120 us.
// - Slot mode one is low 1 to 15 us at slot start.
// - Slot mode zero is low 60 to 120 us at slot start.
// - Zero low time stays strictly shorter than the slot length.
// - At least 1 us released recovery between consecutive slots.
// - Read slot starts with short low strobe of 1 to 15 us.
`timescale 1ns/1ps
`default_nettype none
module swm_master #(
  parameter int CNT_W = swm_pkg::CNT_W,
  parameter int BREAK_CYC = swm_pkg::BREAK_CYC,
  parameter int BREAK_RECOVERY_CYC = swm_pkg::BREAK_RECOVERY_CYC,
  parameter int WRITE_BIT_WINDOW_CYC = swm_pkg::WRITE_BIT_WINDOW_CYC,
  parameter int WRITE_ONE_LOW_CYC = swm_pkg::WRITE_ONE_LOW_CYC,
  parameter int WRITE_ZERO_LOW_CYC = swm_pkg::WRITE_ZERO_LOW_CYC,
  parameter int SAMPLE_FIRST_CYC = swm_pkg::SAMPLE_FIRST_CYC,
  parameter int SAMPLE_SECOND_CYC = swm_pkg::SAMPLE_SECOND_CYC,
  parameter int RESPONSE_TIMEOUT_CYC = swm_pkg::RESPONSE_TIMEOUT_CYC,
  parameter int RELEASE_TIMEOUT_CYC = swm_pkg::RELEASE_TIMEOUT_CYC,
  parameter int BUS_RESET_LOW_CYC = swm_pkg::BUS_RESET_LOW_CYC,
  parameter int BUS_RESET_HIGH_CYC = swm_pkg::BUS_RESET_HIGH_CYC,
  parameter int PRESENCE_SAMPLE_CYC = swm_pkg::PRESENCE_SAMPLE_CYC,
  parameter int SLOT_CYC = swm_pkg::SLOT_CYC,
  parameter int SLOT_ONE_LOW_CYC = swm_pkg::SLOT_ONE_LOW_CYC,
  parameter int SLOT_ZERO_LOW_CYC = swm_pkg::SLOT_ZERO_LOW_CYC,
  parameter int SLOT_RECOVERY_CYC = swm_pkg::SLOT_RECOVERY_CYC,
  parameter int READ_STROBE_CYC = swm_pkg::READ_STROBE_CYC,
  parameter int SLOT_SAMPLE_CYC = swm_pkg::SLOT_SAMPLE_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic mode_slot,
  input wire logic cmd_valid,
  input wire swm_pkg::swm_cmd_t cmd_kind,
  input wire logic cmd_wbit,
  output logic cmd_ready,
  input wire logic line_i,
  output logic line_o,
  output logic line_oe,
  output logic busy,
  output logic rsp_valid,
  output logic rsp_bit,
  output logic rsp_break,
  output logic rsp_presence,
  output logic rsp_error
);
  import swm_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int CNT_MAX = (1 << CNT_W) - 1;

  if (SLOT_ZERO_LOW_CYC >= SLOT_CYC) begin : g_bad_zero
    $error("zero low time must be shorter than the slot");
  end
  if (SLOT_ONE_LOW_CYC >= SLOT_CYC || READ_STROBE_CYC >= SLOT_SAMPLE_CYC) begin : g_bad_slot
    $error("one low time and strobe must end inside the slot");
  end
  if (SLOT_SAMPLE_CYC >= SLOT_CYC) begin : g_bad_ssamp
    $error("slot sample point must fall inside the slot");
  end
  if (WRITE_ZERO_LOW_CYC >= WRITE_BIT_WINDOW_CYC || WRITE_ONE_LOW_CYC < 1) begin : g_bad_pw
    $error("pulse-width low times must end inside the window");
  end
  if (SAMPLE_FIRST_CYC >= SAMPLE_SECOND_CYC) begin : g_bad_samp
    $error("first sample must come before the second");
  end
  if (PRESENCE_SAMPLE_CYC >= BUS_RESET_HIGH_CYC || SLOT_RECOVERY_CYC < 1) begin : g_bad_pres
    $error("presence sample must fall inside the reset high time");
  end
  if (BUS_RESET_LOW_CYC + BUS_RESET_HIGH_CYC > CNT_MAX ||
      BREAK_CYC + BREAK_RECOVERY_CYC > CNT_MAX ||
      RESPONSE_TIMEOUT_CYC > CNT_MAX || RELEASE_TIMEOUT_CYC > CNT_MAX) begin : g_bad_width
    $error("counter too narrow for the programmed times");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_LOW = 7'h02,
    ST_HIGH = 7'h04,
    ST_REC = 7'h08,
    ST_WAIT_EDGE = 7'h10,
    ST_SAMPLE = 7'h20,
    ST_WAIT_HIGH = 7'h40
  } swm_state_t;

  typedef struct packed {
    swm_state_t st;
    swm_cmd_t kind;
    logic wbit;
    logic slot;
    logic first;
    logic line_o;
    logic line_oe;
    logic cmd_ready;
    logic busy;
    logic rsp_valid;
    logic rsp_bit;
    logic rsp_break;
    logic rsp_presence;
    logic rsp_error;
  } swm_master_t;

  swm_master_t q;
  swm_master_t d;
  logic clr;
  logic line_s;
  logic [CNT_W-1:0] el;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True in the last cycle of a phase of n cycles
  function automatic logic reached(input logic [CNT_W-1:0] e, input int n);
    return int'(e) >= n - 1;
  endfunction

  // True in exactly one cycle, n cycles after the phase began
  function automatic logic at_cyc(input logic [CNT_W-1:0] e, input int n);
    return int'(e) == n;
  endfunction

  // Length of the driven-low part of a frame
  function automatic int low_len(input logic slot, input swm_cmd_t k, input logic b);
    int r;
    r = 0;
    if (slot) begin
      case (k)
        SWM_CMD_INIT: r = BUS_RESET_LOW_CYC;
        SWM_CMD_READ: r = READ_STROBE_CYC;
        default: r = b ? SLOT_ONE_LOW_CYC : SLOT_ZERO_LOW_CYC;
      endcase
    end else begin
      case (k)
        SWM_CMD_INIT: r = BREAK_CYC;
        default: r = b ? WRITE_ONE_LOW_CYC : WRITE_ZERO_LOW_CYC;
      endcase
    end
    return r;
  endfunction

  // Total frame length from the falling edge
  function automatic int frame_len(input logic slot, input swm_cmd_t k);
    int r;
    r = 0;
    if (slot) begin
      r = (k == SWM_CMD_INIT) ? BUS_RESET_LOW_CYC + BUS_RESET_HIGH_CYC : SLOT_CYC;
    end else begin
      r = (k == SWM_CMD_INIT) ? BREAK_CYC + BREAK_RECOVERY_CYC : WRITE_BIT_WINDOW_CYC;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  swm_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .pin_i(line_i),
    .level_q(line_s)
  );

  swm_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .clear(clr),
    .elapsed(el)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // One frame per command; the mode is latched so a change mid-frame is harmless
  always_comb begin
    d = q;
    clr = 1'b0;
    d.rsp_valid = 1'b0;
    d.line_o = 1'b0;
    case (q.st)
      ST_IDLE: begin
        d.line_oe = 1'b0;
        d.cmd_ready = 1'b1;
        if (cmd_valid && q.cmd_ready) begin
          d.kind = cmd_kind;
          d.wbit = cmd_wbit;
          d.slot = mode_slot;
          d.cmd_ready = 1'b0;
          d.busy = 1'b1;
          d.rsp_bit = 1'b0;
          d.rsp_break = 1'b0;
          d.rsp_presence = 1'b0;
          d.rsp_error = 1'b0;
          clr = 1'b1;
          if (cmd_kind == SWM_CMD_READ && !mode_slot) begin
            d.st = ST_WAIT_EDGE;
          end else begin
            d.st = ST_LOW;
            d.line_oe = 1'b1;
          end
        end
      end
      ST_LOW: begin
        if (reached(el, low_len(q.slot, q.kind, q.wbit))) begin
          d.line_oe = 1'b0;
          d.st = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (q.slot && q.kind == SWM_CMD_READ && at_cyc(el, SLOT_SAMPLE_CYC)) begin
          d.rsp_bit = line_s;
        end
        if (q.slot && q.kind == SWM_CMD_INIT &&
            at_cyc(el, BUS_RESET_LOW_CYC + PRESENCE_SAMPLE_CYC)) begin
          d.rsp_presence = !line_s;
        end
        if (reached(el, frame_len(q.slot, q.kind))) begin
          clr = 1'b1;
          if (q.slot && q.kind != SWM_CMD_INIT) begin
            d.st = ST_REC;
          end else begin
            d.st = ST_IDLE;
            d.busy = 1'b0;
            d.cmd_ready = 1'b1;
            d.rsp_valid = 1'b1;
          end
        end
      end
      ST_REC: begin
        if (reached(el, SLOT_RECOVERY_CYC)) begin
          d.st = ST_IDLE;
          d.busy = 1'b0;
          d.cmd_ready = 1'b1;
          d.rsp_valid = 1'b1;
        end
      end
      ST_WAIT_EDGE: begin
        if (!line_s) begin
          clr = 1'b1;
          d.st = ST_SAMPLE;
        end else if (reached(el, RESPONSE_TIMEOUT_CYC)) begin
          // Silent slave: report rather than hang
          d.rsp_error = 1'b1;
          d.st = ST_IDLE;
          d.busy = 1'b0;
          d.cmd_ready = 1'b1;
          d.rsp_valid = 1'b1;
        end
      end
      ST_SAMPLE: begin
        if (at_cyc(el, SAMPLE_FIRST_CYC)) begin
          d.first = line_s;
        end
        if (at_cyc(el, SAMPLE_SECOND_CYC)) begin
          clr = 1'b1;
          d.st = ST_WAIT_HIGH;
          case ({q.first, line_s})
            2'h0: d.rsp_break = 1'b1;
            2'h1: d.rsp_bit = 1'b0;
            2'h3: d.rsp_bit = 1'b1;
            default: d.rsp_error = 1'b1;
          endcase
        end
      end
      ST_WAIT_HIGH: begin
        // A slave break may still hold the line; wait it out
        if (line_s || reached(el, RELEASE_TIMEOUT_CYC)) begin
          d.rsp_error = q.rsp_error | !line_s;
          d.st = ST_IDLE;
          d.busy = 1'b0;
          d.cmd_ready = 1'b1;
          d.rsp_valid = 1'b1;
        end
      end
      default: begin
        d.st = ST_IDLE;
        d.line_oe = 1'b0;
        d.busy = 1'b0;
      end
    endcase
  end

  // State register; pin released during reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '{st: ST_IDLE, kind: SWM_CMD_INIT, default: 1'b0};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmd_ready = q.cmd_ready;
  assign line_o = q.line_o;
  assign line_oe = q.line_oe;
  assign busy = q.busy;
  assign rsp_valid = q.rsp_valid;
  assign rsp_bit = q.rsp_bit;
  assign rsp_break = q.rsp_break;
  assign rsp_presence = q.rsp_presence;
  assign rsp_error = q.rsp_error;
endmodule
`default_nettype wire

// *** test/swm_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Wire timing checker for the single-wire master
// ----------------------------------------------------------------
module swm_monitor #(
  parameter int BREAK_CYC = swm_pkg::BREAK_CYC,
  parameter int BREAK_RECOVERY_CYC = swm_pkg::BREAK_RECOVERY_CYC,
  parameter int WRITE_BIT_WINDOW_CYC = swm_pkg::WRITE_BIT_WINDOW_CYC,
  parameter int WRITE_ONE_LOW_CYC = swm_pkg::WRITE_ONE_LOW_CYC,
  parameter int WRITE_ZERO_LOW_CYC = swm_pkg::WRITE_ZERO_LOW_CYC,
  parameter int BUS_RESET_LOW_CYC = swm_pkg::BUS_RESET_LOW_CYC,
  parameter int BUS_RESET_HIGH_CYC = swm_pkg::BUS_RESET_HIGH_CYC,
  parameter int SLOT_CYC = swm_pkg::SLOT_CYC,
  parameter int SLOT_ONE_LOW_CYC = swm_pkg::SLOT_ONE_LOW_CYC,
  parameter int SLOT_ZERO_LOW_CYC = swm_pkg::SLOT_ZERO_LOW_CYC,
  parameter int SLOT_RECOVERY_CYC = swm_pkg::SLOT_RECOVERY_CYC,
  parameter int READ_STROBE_CYC = swm_pkg::READ_STROBE_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic mode_slot,
  input wire logic cmd_valid,
  input wire swm_pkg::swm_cmd_t cmd_kind,
  input wire logic cmd_wbit,
  input wire logic cmd_ready,
  input wire logic line_o,
  input wire logic line_oe,
  input wire logic busy,
  input wire logic rsp_valid,
  input wire logic rsp_bit,
  input wire logic rsp_break,
  input wire logic rsp_error
);
  import swm_pkg::*;
  swm_cmd_t kind_q;
  logic mode_q;
  logic wbit_q;
  int lo_q;
  int hi_q;
  int op_q;
  int exp_lo;
  // Capture each accepted command; count driven, released and total cycles
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      kind_q <= SWM_CMD_INIT;
      mode_q <= 1'b0;
      wbit_q <= 1'b0;
      lo_q <= 0;
      hi_q <= 0;
      op_q <= 0;
    end else begin
      if (cmd_valid && cmd_ready) begin
        kind_q <= cmd_kind;
        mode_q <= mode_slot;
        wbit_q <= cmd_wbit;
      end
      lo_q <= line_oe ? lo_q + 1 : 0;
      hi_q <= (line_oe || (cmd_valid && cmd_ready)) ? 0 : hi_q + 1;
      op_q <= (cmd_valid && cmd_ready) ? 0 : op_q + 1;
    end
  end
  // Expected low width of the one pulse each command except a pulse-width read drives
  always_comb begin
    if (kind_q == SWM_CMD_INIT) exp_lo = mode_q ? BUS_RESET_LOW_CYC : BREAK_CYC;
    else if (mode_q && kind_q == SWM_CMD_READ) exp_lo = READ_STROBE_CYC;
    else if (mode_q) exp_lo = wbit_q ? SLOT_ONE_LOW_CYC : SLOT_ZERO_LOW_CYC;
    else exp_lo = wbit_q ? WRITE_ONE_LOW_CYC : WRITE_ZERO_LOW_CYC;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_accept; cmd_valid && cmd_ready; endsequence
  sequence s_held; busy && !cmd_ready; endsequence
  sequence s_done_pw; rsp_valid && !mode_q; endsequence
  sequence s_done_slot; rsp_valid && mode_q; endsequence
  // A reset that cuts a pulse short is not a width error
  a_low_width: assert property ($fell(line_oe) && !$past(sys_rst) |-> lo_q == exp_lo)
    else $error("driven low width wrong");
  a_break_recover: assert property (s_done_pw ##0 kind_q == SWM_CMD_INIT |-> hi_q >= BREAK_RECOVERY_CYC - 1)
    else $error("break recovery too short");
  a_pw_window: assert property (s_done_pw ##0 kind_q == SWM_CMD_WRITE |->
    op_q >= WRITE_BIT_WINDOW_CYC - 1 && op_q <= WRITE_BIT_WINDOW_CYC + 1)
    else $error("write bit window wrong");
  a_slot_span: assert property (s_done_slot ##0 kind_q != SWM_CMD_INIT |->
    op_q >= SLOT_CYC + SLOT_RECOVERY_CYC - 1 && op_q <= SLOT_CYC + SLOT_RECOVERY_CYC + 1)
    else $error("slot length wrong");
  a_reset_high: assert property (s_done_slot ##0 kind_q == SWM_CMD_INIT |-> hi_q >= BUS_RESET_HIGH_CYC - 1)
    else $error("reset high time too short");
  a_read_quiet: assert property (busy && !mode_q && kind_q == SWM_CMD_READ |-> !line_oe)
    else $error("master drove during read");
  a_error_nodata: assert property (rsp_valid && rsp_error |-> !rsp_bit && !rsp_break)
    else $error("undefined bit stored data");
  a_accept_busy: assert property (s_accept |=> s_held [*2])
    else $error("accepted command not held busy");
  a_drive_low: assert property (line_oe |-> !line_o)
    else $error("wire driven high");
  a_idle_release: assert property (!busy |-> !line_oe)
    else $error("wire driven while idle");
endmodule
bind swm_master swm_monitor #(
  .BREAK_CYC(BREAK_CYC), .BREAK_RECOVERY_CYC(BREAK_RECOVERY_CYC), .WRITE_BIT_WINDOW_CYC(WRITE_BIT_WINDOW_CYC),
  .WRITE_ONE_LOW_CYC(WRITE_ONE_LOW_CYC), .WRITE_ZERO_LOW_CYC(WRITE_ZERO_LOW_CYC),
  .BUS_RESET_LOW_CYC(BUS_RESET_LOW_CYC), .BUS_RESET_HIGH_CYC(BUS_RESET_HIGH_CYC), .SLOT_CYC(SLOT_CYC),
  .SLOT_ONE_LOW_CYC(SLOT_ONE_LOW_CYC), .SLOT_ZERO_LOW_CYC(SLOT_ZERO_LOW_CYC),
  .SLOT_RECOVERY_CYC(SLOT_RECOVERY_CYC), .READ_STROBE_CYC(READ_STROBE_CYC)
) u_swm_monitor (
  .clock, .sys_rst, .mode_slot, .cmd_valid, .cmd_kind, .cmd_wbit, .cmd_ready,
  .line_o, .line_oe, .busy, .rsp_valid, .rsp_bit, .rsp_break, .rsp_error
);
`default_nettype wire

// *** test/swm_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Behavioural slave on the far side of the wire
// ----------------------------------------------------------------
module swm_slave (
  input wire logic clock,
  input wire logic line,
  input wire logic slot_mode,
  input wire logic present,
  input wire logic rbit,
  input wire logic [1:0] reply,
  input wire logic go,
  output logic pull
);
  int lo = 0;
  initial pull = 1'b0;
  // Pull low for n cycles, moving only at falling edges
  task automatic pulse(input int n);
    @(negedge clock);
    pull = 1'b1;
    repeat (n) @(negedge clock);
    pull = 1'b0;
  endtask
  // Low time in slot mode, so a long reset is told apart from a slot
  always @(posedge clock) lo <= (slot_mode && !line) ? lo + 1 : 0;
  // reply after a delay: 0 zero, 1 one, 2 break, 3 high then low
  always @(posedge go) begin
    repeat (8) @(posedge clock);
    case (reply)
      2'h0: pulse(30);
      2'h1: pulse(10);
      2'h2: pulse(55);
      default: begin
        pulse(10);
        repeat (27) @(negedge clock);
        pulse(15);
      end
    endcase
  end
  // presence after a long reset low, then released
  always @(posedge line) begin
    if (slot_mode && present && lo > 80) begin
      repeat (5) @(negedge clock);
      pulse(40);
    end
  end
  // read zero held past the sample point, then released
  always @(negedge line) begin
    if (slot_mode && !rbit && !pull && lo == 0) pulse(20);
  end
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Self-checking bench for the single-wire master
// ----------------------------------------------------------------
module tb;
  import swm_pkg::*;
  // Short counts keep the run brief; expectations follow them
  localparam int BRK = 50, BRR = 20, WIN = 60, RSL = 100, RSH = 100, SLT = 40, REC = 2;
  localparam int W1L = 5, W0L = 30, SP1 = 20, SP2 = 45, RTO = 200, PRS = 30, S1L = 4, S0L = 30, STB = 2, SSP = 10;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic mode_slot = 1'b0;
  logic cmd_valid = 1'b0;
  swm_cmd_t cmd_kind = SWM_CMD_INIT;
  logic cmd_wbit = 1'b0;
  logic cmd_ready, line_o, line_oe, busy, rsp_valid, rsp_bit, rsp_break, rsp_presence, rsp_error;
  logic line, pull, present = 1'b0, rbit = 1'b1, go = 1'b0;
  logic [1:0] reply = 2'h0;
  int miscompares = 0, n_checks = 0, cyc = 0, lat = 0;
  // Pull-up wins whenever neither party drives low
  assign line = !(line_oe || pull);
  always #20 clock = ~clock;
  swm_master #(
    .BREAK_CYC(BRK), .BREAK_RECOVERY_CYC(BRR), .WRITE_BIT_WINDOW_CYC(WIN), .WRITE_ONE_LOW_CYC(W1L),
    .WRITE_ZERO_LOW_CYC(W0L), .SAMPLE_FIRST_CYC(SP1), .SAMPLE_SECOND_CYC(SP2), .RESPONSE_TIMEOUT_CYC(RTO),
    .RELEASE_TIMEOUT_CYC(RTO), .BUS_RESET_LOW_CYC(RSL), .BUS_RESET_HIGH_CYC(RSH), .PRESENCE_SAMPLE_CYC(PRS),
    .SLOT_CYC(SLT), .SLOT_ONE_LOW_CYC(S1L), .SLOT_ZERO_LOW_CYC(S0L), .SLOT_RECOVERY_CYC(REC),
    .READ_STROBE_CYC(STB), .SLOT_SAMPLE_CYC(SSP)
  ) u_swm_master (
    .clock, .sys_rst, .mode_slot, .cmd_valid, .cmd_kind, .cmd_wbit, .cmd_ready, .line_i(line), .line_o,
    .line_oe, .busy, .rsp_valid, .rsp_bit, .rsp_break, .rsp_presence, .rsp_error
  );
  swm_slave u_swm_slave (
    .clock, .line, .slot_mode(mode_slot), .present, .rbit, .reply, .go, .pull
  );
  task automatic stop_test();
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t ns: %s", $time, msg);
    end
  endtask
  // Hold the request until taken, then count cycles to the response
  task automatic run_cmd(input swm_cmd_t k, input logic b);
    int w;
    w = 0;
    cmd_kind = k;
    cmd_wbit = b;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && w < 100) begin
      @(negedge clock);
      w++;
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    lat = 0;
    while (rsp_valid !== 1'b1 && lat < 2000) begin
      @(negedge clock);
      lat++;
    end
    chk(w < 100 && lat < 2000, "command never answered");
  endtask
  task automatic t_pw_init_write();
    mode_slot = 1'b0;
    run_cmd(SWM_CMD_INIT, 1'b0);
    chk(lat >= BRK + BRR - 1 && lat <= BRK + BRR + 1, "break plus recovery length");
    // Back to back writes of both values
    for (int b = 0; b < 2; b++) begin
      run_cmd(SWM_CMD_WRITE, b[0]);
      chk(lat >= WIN - 1 && lat <= WIN + 1, "write window length");
    end
  endtask
  task automatic t_pw_read();
    logic [2:0] exp [4] = '{3'b000, 3'b100, 3'b010, 3'b001};
    mode_slot = 1'b0;
    // All four sample cases: bit, break and error flags
    for (int i = 0; i < 4; i++) begin
      reply = i[1:0];
      go = 1'b1;
      run_cmd(SWM_CMD_READ, 1'b0);
      chk({rsp_bit, rsp_break, rsp_error} === exp[i], "read sample outcome");
      go = 1'b0;
      @(negedge clock);
    end
  endtask
  task automatic t_slot_init();
    mode_slot = 1'b1;
    for (int p = 1; p >= 0; p--) begin
      present = p[0];
      run_cmd(SWM_CMD_INIT, 1'b0);
      chk(rsp_presence === p[0], "presence flag");
      chk(lat >= RSL + RSH - 1 && lat <= RSL + RSH + 1, "reset sequence length");
    end
  endtask
  task automatic t_slot_rw();
    mode_slot = 1'b1;
    for (int b = 0; b < 2; b++) begin
      rbit = 1'b1;
      run_cmd(SWM_CMD_WRITE, b[0]);
      chk(lat >= SLT + REC - 1 && lat <= SLT + REC + 1, "write slot length");
      rbit = b[0];
      run_cmd(SWM_CMD_READ, 1'b0);
      chk(rsp_bit === b[0], "read slot bit");
    end
    rbit = 1'b1;
  endtask
  // Reset in mid-break must free the wire, and the next command still works
  task automatic t_reset_mid();
    mode_slot = 1'b0;
    cmd_kind = SWM_CMD_INIT;
    cmd_valid = 1'b1;
    repeat (3) @(negedge clock);
    cmd_valid = 1'b0;
    repeat (10) @(negedge clock);
    sys_rst = 1'b1;
    @(negedge clock);
    chk(line_oe === 1'b0 && busy === 1'b0, "wire freed by reset");
    sys_rst = 1'b0;
    @(negedge clock);
    run_cmd(SWM_CMD_INIT, 1'b0);
    chk(lat >= BRK + BRR - 1 && lat <= BRK + BRR + 1, "break after reset");
  endtask
  // Hang guard well above the thousand or so cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    t_pw_init_write();
    t_pw_read();
    t_slot_init();
    t_slot_rw();
    t_reset_mid();
    stop_test();
  end
endmodule
`default_nettype wire
